// ### crmc_pkg.sv
// Constants, types and register map for the custom reference monitor configuration block
// Overview of operation
// - Coarse high limit A bits 15:8 come from its upper register byte.
// - Each custom A sample window spans the programmed cycle field plus one.
// - Prescale bit set makes the coarse monitor divide reference A by four.
// - Multiplier B is 14 bits: low byte 7:0, next register bits 5:0.
// - Period low bound B is the lower limit of its single-cycle monitor.
// - Coarse high limit A bits 7:0 come from the preceding register.
package crmc_pkg;

  // APB geometry
  localparam int CRMC_ADDR_W = 12;
  localparam int CRMC_DATA_W = 32;
  localparam int CRMC_IDX_W = 10;
  localparam logic [1:0] CRMC_ALIGNED = 2'h0;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_HIGH_LIMIT_A_LOWER = 10'h06d;
  localparam logic [9:0] IDX_HIGH_LIMIT_A_UPPER = 10'h06e;
  localparam logic [9:0] IDX_CYCLE_COUNT_A = 10'h06f;
  localparam logic [9:0] IDX_PRESCALE_A = 10'h070;
  localparam logic [9:0] IDX_MULTIPLIER_B_LOW = 10'h071;
  localparam logic [9:0] IDX_MULTIPLIER_B_HIGH = 10'h072;
  localparam logic [9:0] IDX_PERIOD_LOW_LIMIT_B = 10'h073;
  localparam logic [9:0] IDX_MONITOR_STATUS = 10'h080;
  localparam logic [9:0] IDX_MEASURED_COUNT_A = 10'h081;

  // Reset values and writable-bit masks
  localparam logic [7:0] CRMC_REG_RESET = 8'h00;
  localparam logic [7:0] CRMC_MASK_FULL = 8'hff;
  localparam logic [7:0] CRMC_MASK_PRESCALE = 8'h01;
  localparam logic [7:0] CRMC_MASK_MULT_HIGH = 8'h3f;

  // Status bit positions
  localparam int STAT_A_OVER = 0;
  localparam int STAT_B_UNDER = 1;
  localparam int STAT_A_BUSY = 2;

  // Prescaler: pass one reference edge out of four
  localparam logic [1:0] CRMC_PRESCALE_LAST = 2'h3;
  localparam logic [1:0] CRMC_PRESCALE_RESET = 2'h0;

  // Multiplier B unit, in hertz
  localparam int CRMC_MULT_UNIT_HZ = 8000;

  localparam logic [15:0] CRMC_COUNT_MAX = 16'hffff;
  localparam logic [7:0] CRMC_PERIOD_MAX = 8'hff;

  typedef enum logic [1:0] {
    CRMC_IDLE = 2'b00,
    CRMC_RUN = 2'b01,
    CRMC_DONE = 2'b11
  } crmc_win_t;

  typedef struct packed {
    logic [15:0] high_limit_a;
    logic [7:0] cycle_count_a_field;
    logic prescale_a_enable;
    logic [13:0] multiplier_b;
    logic [7:0] period_low_bound_b;
  } crmc_cfg_t;

  typedef struct packed {
    logic b_under;
    logic a_over;
  } crmc_flag_t;

endpackage : crmc_pkg

// ### crmc_top.sv
// APB register slice and reference monitors for custom configurations A and B
module crmc_top
  import crmc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [CRMC_ADDR_W-1:0] paddr,
  input wire logic [CRMC_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [CRMC_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Reference edges, one-cycle pulses
  input wire logic ref_a_tick,
  input wire logic ref_b_tick,
  // Configuration and monitor results
  output crmc_cfg_t cfg,
  output crmc_flag_t out_of_range
);

  logic [7:0] high_limit_a_lower_bits;
  logic [7:0] high_limit_a_upper_bits;
  logic [7:0] cycle_count_a_field;
  logic [7:0] prescale_a_reg;
  logic [7:0] multiplier_b_lower_bits;
  logic [7:0] multiplier_b_upper_bits;
  logic [7:0] period_low_bound_b;
  logic [15:0] measured_a;
  logic [15:0] last_count_a;
  logic [7:0] cyc_a;
  logic [1:0] pre_cnt;
  logic pre_tick;
  logic [7:0] period_b;
  logic seen_b;
  logic set_a_over;
  logic set_b_under;
  logic setup;
  logic hit;
  logic wr;
  logic [CRMC_IDX_W-1:0] idx;
  logic [CRMC_DATA_W-1:0] next_prdata;
  crmc_win_t win_a;
  crmc_win_t next_win_a;

  function automatic logic idx_hit(input logic [CRMC_IDX_W-1:0] i);
    return (i >= IDX_HIGH_LIMIT_A_LOWER && i <= IDX_PERIOD_LOW_LIMIT_B) ||
           i == IDX_MONITOR_STATUS || i == IDX_MEASURED_COUNT_A;
  endfunction : idx_hit

  function automatic logic [7:0] masked(input logic [7:0] d, input logic [7:0] m);
    return d & m;
  endfunction : masked

  assign idx = paddr[CRMC_ADDR_W-1:2];
  assign hit = idx_hit(idx) && paddr[1:0] == CRMC_ALIGNED;
  assign setup = psel && !penable;
  assign wr = psel && penable && pready && pwrite && !pslverr && pstrb[0];

  // Bus handshake: zero-wait access phase, error on unmapped or misaligned
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= setup;
      pslverr <= setup && !hit;
      if (setup) begin
        prdata <= next_prdata;
      end
    end
  end

  always_comb begin
    next_prdata = '0;
    if (hit && !pwrite) begin
      unique case (idx)
        IDX_HIGH_LIMIT_A_LOWER: next_prdata[7:0] = high_limit_a_lower_bits;
        IDX_HIGH_LIMIT_A_UPPER: next_prdata[7:0] = high_limit_a_upper_bits;
        IDX_CYCLE_COUNT_A: next_prdata[7:0] = cycle_count_a_field;
        IDX_PRESCALE_A: next_prdata[7:0] = prescale_a_reg;
        IDX_MULTIPLIER_B_LOW: next_prdata[7:0] = multiplier_b_lower_bits;
        IDX_MULTIPLIER_B_HIGH: next_prdata[7:0] = multiplier_b_upper_bits;
        IDX_PERIOD_LOW_LIMIT_B: next_prdata[7:0] = period_low_bound_b;
        IDX_MONITOR_STATUS: begin
          next_prdata[STAT_A_OVER] = out_of_range.a_over;
          next_prdata[STAT_B_UNDER] = out_of_range.b_under;
          next_prdata[STAT_A_BUSY] = win_a != CRMC_IDLE;
        end
        IDX_MEASURED_COUNT_A: next_prdata[15:0] = last_count_a;
        default: next_prdata = '0;
      endcase
    end
  end

  // Configuration registers; reserved bits are held at zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_limit_a_lower_bits <= CRMC_REG_RESET;
      high_limit_a_upper_bits <= CRMC_REG_RESET;
      cycle_count_a_field <= CRMC_REG_RESET;
      prescale_a_reg <= CRMC_REG_RESET;
      multiplier_b_lower_bits <= CRMC_REG_RESET;
      multiplier_b_upper_bits <= CRMC_REG_RESET;
      period_low_bound_b <= CRMC_REG_RESET;
    end else if (wr) begin
      unique case (idx)
        IDX_HIGH_LIMIT_A_LOWER: high_limit_a_lower_bits <= masked(pwdata[7:0], CRMC_MASK_FULL);
        IDX_HIGH_LIMIT_A_UPPER: high_limit_a_upper_bits <= masked(pwdata[7:0], CRMC_MASK_FULL);
        IDX_CYCLE_COUNT_A: cycle_count_a_field <= masked(pwdata[7:0], CRMC_MASK_FULL);
        IDX_PRESCALE_A: prescale_a_reg <= masked(pwdata[7:0], CRMC_MASK_PRESCALE);
        IDX_MULTIPLIER_B_LOW: multiplier_b_lower_bits <= masked(pwdata[7:0], CRMC_MASK_FULL);
        IDX_MULTIPLIER_B_HIGH: multiplier_b_upper_bits <= masked(pwdata[7:0], CRMC_MASK_MULT_HIGH);
        IDX_PERIOD_LOW_LIMIT_B: period_low_bound_b <= masked(pwdata[7:0], CRMC_MASK_FULL);
        default: ;
      endcase
    end
  end

  // High limit A assembled from two bytes
  assign cfg.high_limit_a = {high_limit_a_upper_bits, high_limit_a_lower_bits};
  assign cfg.cycle_count_a_field = cycle_count_a_field;
  assign cfg.prescale_a_enable = prescale_a_reg[0];
  // Multiplier B assembled to 14 bits
  assign cfg.multiplier_b = {multiplier_b_upper_bits[5:0], multiplier_b_lower_bits};
  assign cfg.period_low_bound_b = period_low_bound_b;

  // Divide reference A by four when enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt <= CRMC_PRESCALE_RESET;
    end else if (!cfg.prescale_a_enable) begin
      pre_cnt <= CRMC_PRESCALE_RESET;
    end else if (ref_a_tick) begin
      pre_cnt <= pre_cnt + 2'h1;
    end
  end

  assign pre_tick = ref_a_tick && (!cfg.prescale_a_enable || pre_cnt == CRMC_PRESCALE_LAST);

  // Window of cycle field plus one prescaled reference cycles
  always_comb begin
    next_win_a = win_a;
    unique case (win_a)
      CRMC_IDLE: if (pre_tick) next_win_a = CRMC_RUN;
      CRMC_RUN: if (pre_tick && cyc_a == cycle_count_a_field) next_win_a = CRMC_DONE;
      CRMC_DONE: next_win_a = CRMC_IDLE;
      default: next_win_a = CRMC_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_a <= CRMC_IDLE;
      cyc_a <= CRMC_REG_RESET;
      measured_a <= '0;
    end else begin
      win_a <= next_win_a;
      if (win_a == CRMC_IDLE) begin
        cyc_a <= CRMC_REG_RESET;
        measured_a <= '0;
      end else if (win_a == CRMC_RUN) begin
        if (measured_a != CRMC_COUNT_MAX) begin
          measured_a <= measured_a + 16'h1;
        end
        if (pre_tick) begin
          cyc_a <= cyc_a + 8'h1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_count_a <= '0;
    end else if (win_a == CRMC_DONE) begin
      last_count_a <= measured_a;
    end
  end

  // Single-cycle period of reference B against its low bound
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_b <= '0;
      seen_b <= 1'b0;
    end else if (ref_b_tick) begin
      period_b <= 8'h1;
      seen_b <= 1'b1;
    end else if (period_b != CRMC_PERIOD_MAX) begin
      period_b <= period_b + 8'h1;
    end
  end

  assign set_a_over = win_a == CRMC_DONE && measured_a > cfg.high_limit_a;
  assign set_b_under = ref_b_tick && seen_b && period_b < period_low_bound_b;

  // Sticky flags, write one to clear; a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_of_range <= '0;
    end else begin
      if (set_a_over) begin
        out_of_range.a_over <= 1'b1;
      end else if (wr && idx == IDX_MONITOR_STATUS && pwdata[STAT_A_OVER]) begin
        out_of_range.a_over <= 1'b0;
      end
      if (set_b_under) begin
        out_of_range.b_under <= 1'b1;
      end else if (wr && idx == IDX_MONITOR_STATUS && pwdata[STAT_B_UNDER]) begin
        out_of_range.b_under <= 1'b0;
      end
    end
  end

  default clocking crmc_cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_win_end;
    win_a == CRMC_RUN && pre_tick && cyc_a == cycle_count_a_field;
  endsequence

  sequence s_win_report;
    win_a == CRMC_DONE ##1 win_a == CRMC_IDLE;
  endsequence

  chk_upper_limit_write: assert property (
    wr && idx == IDX_HIGH_LIMIT_A_UPPER |=> cfg.high_limit_a[15:8] == $past(pwdata[7:0]))
    else $error("high limit A upper byte not taken");

  chk_window_length: assert property (
    s_win_end |=> s_win_report)
    else $error("window A did not end after cycle field plus one");

  chk_window_hold: assert property (
    win_a == CRMC_RUN && !(pre_tick && cyc_a == cycle_count_a_field) |=> win_a == CRMC_RUN)
    else $error("window A ended early");

  chk_prescale_divide: assert property (
    cfg.prescale_a_enable && ref_a_tick && pre_cnt != CRMC_PRESCALE_LAST |-> !pre_tick)
    else $error("prescaled edge passed too soon");

  chk_multiplier_high: assert property (
    wr && idx == IDX_MULTIPLIER_B_HIGH |=>
      cfg.multiplier_b[13:8] == $past(pwdata[5:0]) && multiplier_b_upper_bits[7:6] == 2'h0)
    else $error("multiplier B upper bits wrong");

  chk_low_bound_b: assert property (
    wr && idx == IDX_PERIOD_LOW_LIMIT_B |=> cfg.period_low_bound_b == $past(pwdata[7:0]))
    else $error("period low bound B not taken");

  chk_lower_limit_write: assert property (
    wr && idx == IDX_HIGH_LIMIT_A_LOWER |=> cfg.high_limit_a[7:0] == $past(pwdata[7:0]))
    else $error("high limit A lower byte not taken");

  chk_flag_a_set: assert property (
    win_a == CRMC_DONE && measured_a > cfg.high_limit_a |=> out_of_range.a_over)
    else $error("over limit A not flagged");

  chk_flag_b_set: assert property (
    ref_b_tick && seen_b && period_b < period_low_bound_b |=> out_of_range.b_under ##1
      (out_of_range.b_under || $past(wr)))
    else $error("under bound B not flagged or lost");

endmodule : crmc_top

// ### crmc_top_tb.sv
// Self-checking bench for the custom reference monitor configuration block
module crmc_top_tb
  import crmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ta = 1'b0, tb = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, er;
  crmc_cfg_t cfg;
  crmc_flag_t out_of_range;
  int err_total = 0, cmp_count = 0;
  logic [31:0] seed = 32'h3a;
  logic [7:0] model [7];
  logic [7:0] mask [7] = '{8'hff, 8'hff, 8'hff, 8'h01, 8'hff, 8'h3f, 8'hff};

  always #2.5 pclk = ~pclk;

  crmc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ref_a_tick(ta), .ref_b_tick(tb), .cfg(cfg),
    .out_of_range(out_of_range));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic logic [11:0] ra(input int i);
    return {IDX_HIGH_LIMIT_A_LOWER + 10'(i), 2'h0};
  endfunction : ra

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask : check

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  // Setup, access, then hold until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    if (n == 50) check("pready", 32'h1, 32'h0);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input int i, input logic [31:0] d);
    apb(1'b1, ra(i), d);
    model[i] = d[7:0] & mask[i];
  endtask : wr

  task automatic verify();
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, ra(i), 32'h0);
      check("register", {24'h0, model[i]}, rd);
      check("error", 32'h0, {31'h0, er});
    end
    check("high limit a", {16'h0, model[1], model[0]}, {16'h0, cfg.high_limit_a});
    check("cycle a", {24'h0, model[2]}, {24'h0, cfg.cycle_count_a_field});
    check("prescale a", {24'h0, model[3]}, {31'h0, cfg.prescale_a_enable});
    check("mult b", {18'h0, model[5][5:0], model[4]}, {18'h0, cfg.multiplier_b});
    check("low bound b", {24'h0, model[6]}, {24'h0, cfg.period_low_bound_b});
  endtask : verify

  // Reference edges exactly p cycles apart
  task automatic ticks(input logic b, input int n, input int p);
    repeat (n) begin
      @(posedge pclk);
      tb <= b;
      ta <= ~b;
      @(posedge pclk);
      tb <= 1'b0;
      ta <= 1'b0;
      repeat (p - 2) @(posedge pclk);
    end
    repeat (4) @(posedge pclk);
  endtask : ticks

  // Latched window count and over flag against the register model
  task automatic count_a(input int p);
    int e;
    e = (model[2] + 1) * p * (model[3][0] ? 4 : 1);
    apb(1'b0, 12'h204, 32'h0);
    check("count a", 32'(e), rd);
    check("a over", {31'h0, e > {model[1], model[0]}}, {31'h0, out_of_range.a_over});
  endtask : count_a

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    foreach (model[i]) model[i] = 8'h00;
    verify();
    $display("test reset values done");
    repeat (3) begin
      for (int i = 0; i < 7; i++) wr(i, xs());
      verify();
    end
    $display("test random registers done");
    pstrb <= 4'h0;
    apb(1'b1, ra(6), 32'h5a);
    pstrb <= 4'hf;
    apb(1'b1, 12'h1d0, 32'h77);
    check("unmapped write", 32'h1, {31'h0, er});
    apb(1'b0, 12'h1d0, 32'h0);
    check("unmapped read", 32'h1, {31'h0, er});
    check("unmapped data", 32'h0, rd);
    apb(1'b0, 12'h1c6, 32'h0);
    check("misaligned", 32'h1, {31'h0, er});
    verify();
    $display("test refused accesses done");
    wr(6, 32'd10);
    apb(1'b1, 12'h200, 32'h3);
    ticks(1'b1, 3, 20);
    check("b under", 32'h0, {31'h0, out_of_range.b_under});
    ticks(1'b1, 3, 5);
    check("b under", 32'h1, {31'h0, out_of_range.b_under});
    apb(1'b0, 12'h200, 32'h0);
    check("status", 32'h2, rd);
    apb(1'b1, 12'h200, 32'h2);
    @(posedge pclk);
    check("b cleared", 32'h0, {31'h0, out_of_range.b_under});
    $display("test monitor b done");
    // window of field plus one cycles
    wr(0, 32'h30);
    wr(1, 32'h00);
    wr(2, 32'h03);
    wr(3, 32'h00);
    apb(1'b1, 12'h200, 32'h3);
    ticks(1'b0, 5, 10);
    count_a(10);
    // divide by four lengthens the window
    wr(3, 32'h1);
    ticks(1'b0, 20, 10);
    count_a(10);
    $display("test monitor a done");
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    complete_run();
  end
endmodule : crmc_top_tb
